// >>> hub_dma_priority_arbiter.sv
// peripheral hub: spoke router, cpu/dma arbiter, dma engine and fifo
//
// Behaviour
// R1 - cpu and dma start transactions independently
// R2 - eight spokes, each carrying transfers in parallel
// R3 - cpu and dma on different spokes proceed together
// R4 - dma read and write on different spokes overlap
// R5 - element sizes of 8, 16, 24, 32 bits
// R6 - spoke taken from address field, spokes 0..7
// R7 - 24 channels share 128 descriptors
// R8 - descriptors writable at run time and chainable
// R9 - eight priority levels, lower number wins
// R10 - start by signal, cpu or finished channel
// R11 - two interrupt events per transfer
// R12 - channels can be stalled or cancelled
// R13 - length 1 byte to 64 KB or endless
// R14 - cpu wins a contended spoke
// R15 - cpu yields after its access if dma waits
// R16 - higher priority takes over after current burst
// R17 - fairness slots give levels 2..7 halving shares
// R18 - levels 0 and 1 bypass fairness entirely
// R19 - equal level requests rotate round robin
// R20 - per channel head-of-line setting skips rotation
// R21 - fairness off means strict priority only
// R22 - one descriptor moves source to sink
// R23 - one grant per spoke, held until done
// R24 - window counter allots halving slots per level
`timescale 1ns/10ps

module hub_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != (AW+1)'(D));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : hub_fifo

module hub_dma_priority_arbiter import hub_pkg::*; #(
  parameter int NCH = NUM_CH,
  parameter int NTD = NUM_TD
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_req,
  input wire logic [31:0] cpu_addr,
  output logic cpu_ack,
  output logic [NUM_SPOKES-1:0] cpu_gnt,
  output logic [NUM_SPOKES-1:0] dma_rd_gnt,
  output logic [NUM_SPOKES-1:0] dma_wr_gnt,
  output logic [31:0] dma_rd_addr,
  output logic [31:0] dma_wr_addr,
  output logic [DATA_W-1:0] dma_wr_data,
  output logic [1:0] dma_size_m1,
  input wire logic [NUM_SPOKES-1:0] spoke_done,
  input wire logic [DATA_W-1:0] dma_rdata,
  input wire logic td_wr,
  input wire logic [TD_IDX_W-1:0] td_wr_idx,
  input wire td_t td_wr_data,
  input wire ch_cfg_t [NCH-1:0] ch_cfg,
  input wire logic fair_en,
  input wire logic [NCH-1:0] ch_trig_sig,
  input wire logic [NCH-1:0] ch_cpu_trig,
  input wire logic [NCH-1:0] ch_stall,
  input wire logic [NCH-1:0] ch_cancel,
  output logic [NCH-1:0] ch_busy,
  output logic [NCH-1:0] irq_td,
  output logic [NCH-1:0] irq_end
);
  localparam int CW = $clog2(NCH);

  td_t td_mem [NTD];
  logic [NCH-1:0] trig_s1_reg, trig_s2_reg, trig_s3_reg, trig_filt_reg;
  logic [NCH-1:0] trig_rise;
  logic [NCH-1:0] active_reg, fresh_reg;
  logic [TD_IDX_W-1:0] ch_td_reg [NCH];
  logic [LEFT_W-1:0] ch_left_reg [NCH];
  logic [15:0] ch_off_reg [NCH];
  eng_state_t state_reg;
  logic [CW-1:0] eng_ch_reg;
  td_t td_reg;
  logic [LEFT_W-1:0] left_reg;
  logic [15:0] rd_off_reg, wr_off_reg;
  logic [2:0] rd_cnt_reg, wr_cnt_reg;
  logic [CW-1:0] rr_ptr_reg [NUM_LVL];
  logic [WIN_W-1:0] win_reg;
  logic [NUM_SPOKES-1:0] cpu_gnt_reg, rd_gnt_reg, wr_gnt_reg, cpu_last_reg;
  logic [NUM_SPOKES-1:0] cpu_pick, rd_pick, wr_pick;
  logic cpu_ack_reg;
  logic [31:0] rd_addr_reg, wr_addr_reg;
  logic [DATA_W-1:0] wr_data_reg;
  logic [1:0] size_reg;
  logic [NCH-1:0] irq_td_reg, irq_end_reg;
  logic [NCH-1:0] ch_req;
  logic [NUM_LVL-1:0] lvl_req;
  logic [2:0] sel_lvl, slot_lvl;
  logic slot_ok, win_ok, hol_hit, use_rr;
  logic [CW-1:0] win_ch;
  logic [31:0] rd_addr, wr_addr;
  logic [2:0] elem_bytes;
  logic rd_stop, rd_go, wr_go, burst_end;
  logic f_in_ready, f_out_valid;
  logic [DATA_W-1:0] f_out_data;
  logic step_done, step_end;

  assign cpu_ack = cpu_ack_reg;
  assign cpu_gnt = cpu_gnt_reg;
  assign dma_rd_gnt = rd_gnt_reg;
  assign dma_wr_gnt = wr_gnt_reg;
  assign dma_rd_addr = rd_addr_reg;
  assign dma_wr_addr = wr_addr_reg;
  assign dma_wr_data = wr_data_reg;
  assign dma_size_m1 = size_reg;
  assign ch_busy = active_reg;
  assign irq_td = irq_td_reg;
  assign irq_end = irq_end_reg;

  // descriptor pool, writable at any time
  always_ff @(posedge clk) begin
    if (td_wr) begin
      td_mem[td_wr_idx] <= td_wr_data; // [R7] [R8]
    end
  end

  // routed trigger pins: three stages, 2nd and 3rd must agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      trig_s3_reg <= '0;
      trig_filt_reg <= '0;
    end else begin
      trig_s1_reg <= ch_trig_sig;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
      trig_filt_reg <= (trig_s2_reg & trig_s3_reg) | (trig_filt_reg & (trig_s2_reg | trig_s3_reg));
    end
  end
  assign trig_rise = trig_s2_reg & trig_s3_reg & ~trig_filt_reg;

  // engine derived terms
  assign elem_bytes = {1'b0, td_reg.size_m1} + 3'h1; // [R5]
  assign rd_addr = td_reg.src + (td_reg.src_inc ? {16'h0, rd_off_reg} : 32'h0);
  assign wr_addr = td_reg.dst + (td_reg.dst_inc ? {16'h0, wr_off_reg} : 32'h0);
  assign rd_stop = (left_reg == '0) && !td_reg.endless; // [R13]
  assign rd_go = (state_reg == E_RUN) && (rd_cnt_reg != 3'(BURST_LEN)) && !rd_stop
                 && f_in_ready && (rd_gnt_reg == '0);
  assign wr_go = (state_reg == E_RUN) && f_out_valid && (wr_gnt_reg == '0);
  assign burst_end = (state_reg == E_RUN) && (rd_cnt_reg == wr_cnt_reg) && (rd_gnt_reg == '0)
                     && (wr_gnt_reg == '0) && !f_out_valid
                     && ((rd_cnt_reg == 3'(BURST_LEN)) || rd_stop); // [R16]
  assign step_done = (state_reg == E_STEP) && rd_stop;
  assign step_end = step_done && !td_reg.chain;
  assign ch_req = active_reg & ~ch_stall; // [R12]

  // fairness slot: trailing ones of the window counter pick the level
  always_comb begin
    slot_lvl = 3'(FAIR_FIRST_LVL);
    slot_ok = 1'b0;
    for (int i = 0; i <= FAIR_LAST_LVL - FAIR_FIRST_LVL; i++) begin
      if (!slot_ok && !win_reg[i]) begin
        slot_lvl = 3'(FAIR_FIRST_LVL + i); // [R24]
        slot_ok = 1'b1;
      end
    end
  end

  // channel selection: level, then head-of-line, then rotation
  always_comb begin
    int idx;
    idx = 0;
    lvl_req = '0;
    sel_lvl = '0;
    win_ok = 1'b0;
    hol_hit = 1'b0;
    use_rr = 1'b0;
    win_ch = '0;
    for (int c = 0; c < NCH; c++) begin
      if (ch_req[c]) begin
        lvl_req[ch_cfg[c].prio] = 1'b1;
      end
    end
    for (int l = NUM_LVL - 1; l >= 0; l--) begin
      if (lvl_req[l]) begin
        sel_lvl = 3'(l); // [R9] [R21]
      end
    end
    if (fair_en && !lvl_req[0] && !lvl_req[1] && slot_ok && lvl_req[slot_lvl]) begin
      sel_lvl = slot_lvl; // [R17] [R18]
    end
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ch_req[c] && ch_cfg[c].prio == sel_lvl && ch_cfg[c].no_rr) begin
        win_ch = CW'(c); // [R20]
        hol_hit = 1'b1;
      end
    end
    for (int k = 1; k <= NCH; k++) begin
      idx = int'(rr_ptr_reg[sel_lvl]) + k;
      if (idx >= NCH) begin
        idx = idx - NCH;
      end
      if (!hol_hit && !use_rr && ch_req[idx] && ch_cfg[idx].prio == sel_lvl) begin
        win_ch = CW'(idx); // [R19]
        use_rr = 1'b1;
      end
    end
    win_ok = hol_hit | use_rr;
  end

  // arbitration bookkeeping: rotation pointers and fairness window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_reg <= '0;
      for (int l = 0; l < NUM_LVL; l++) begin
        rr_ptr_reg[l] <= CW'(NCH - 1);
      end
    end else if (state_reg == E_IDLE && win_ok) begin
      if (use_rr) begin
        rr_ptr_reg[sel_lvl] <= win_ch; // [R19]
      end
      if (fair_en && sel_lvl >= 3'(FAIR_FIRST_LVL)) begin
        win_reg <= win_reg + 1'b1; // [R24]
      end
    end
  end

  // per spoke arbitration, cpu first but yields once to waiting dma
  always_comb begin
    logic cpu_w, rd_w, wr_w;
    cpu_w = 1'b0;
    rd_w = 1'b0;
    wr_w = 1'b0;
    cpu_pick = '0;
    rd_pick = '0;
    wr_pick = '0;
    for (int s = 0; s < NUM_SPOKES; s++) begin
      cpu_w = cpu_req && !cpu_ack_reg && (cpu_gnt_reg == '0) && (cpu_addr[SPOKE_LSB +: 3] == 3'(s)); // [R1] [R6]
      rd_w = rd_go && (rd_addr[SPOKE_LSB +: 3] == 3'(s));
      wr_w = wr_go && (wr_addr[SPOKE_LSB +: 3] == 3'(s));
      if (!cpu_gnt_reg[s] && !rd_gnt_reg[s] && !wr_gnt_reg[s]) begin // [R23]
        if (cpu_w && !(cpu_last_reg[s] && (rd_w || wr_w))) begin
          cpu_pick[s] = 1'b1; // [R14] [R15]
        end else if (wr_w) begin
          wr_pick[s] = 1'b1; // [R4]
        end else if (rd_w) begin
          rd_pick[s] = 1'b1;
        end
      end
    end
  end

  // spoke grants held until the spoke reports done
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_gnt_reg <= '0;
      rd_gnt_reg <= '0;
      wr_gnt_reg <= '0;
      cpu_last_reg <= '0;
      cpu_ack_reg <= 1'b0;
    end else begin
      cpu_gnt_reg <= (cpu_gnt_reg & ~spoke_done) | cpu_pick; // [R2] [R3] [R23]
      rd_gnt_reg <= (rd_gnt_reg & ~spoke_done) | rd_pick;
      wr_gnt_reg <= (wr_gnt_reg & ~spoke_done) | wr_pick;
      cpu_last_reg <= (cpu_last_reg | cpu_pick) & ~(rd_pick | wr_pick); // [R15]
      cpu_ack_reg <= |(cpu_gnt_reg & spoke_done);
    end
  end

  // element staging between read and write side
  hub_fifo #(
    .W(DATA_W),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(|(rd_gnt_reg & spoke_done)),
    .in_ready(f_in_ready),
    .in_data(dma_rdata),
    .out_valid(f_out_valid),
    .out_ready(|wr_pick),
    .out_data(f_out_data)
  );

  // dma engine: pick channel, load descriptor, run one burst, save
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= E_IDLE;
      eng_ch_reg <= '0;
      td_reg <= '0;
      left_reg <= '0;
      rd_off_reg <= '0;
      wr_off_reg <= '0;
      rd_cnt_reg <= '0;
      wr_cnt_reg <= '0;
    end else begin
      case (state_reg)
        E_IDLE: begin
          if (win_ok) begin
            eng_ch_reg <= win_ch;
            state_reg <= E_LOAD;
          end
        end
        E_LOAD: begin
          td_reg <= td_mem[ch_td_reg[eng_ch_reg]]; // [R22]
          left_reg <= fresh_reg[eng_ch_reg] ? ({1'b0, td_mem[ch_td_reg[eng_ch_reg]].len_m1} + 17'h1)
                                            : ch_left_reg[eng_ch_reg]; // [R13]
          rd_off_reg <= fresh_reg[eng_ch_reg] ? 16'h0 : ch_off_reg[eng_ch_reg];
          wr_off_reg <= fresh_reg[eng_ch_reg] ? 16'h0 : ch_off_reg[eng_ch_reg];
          rd_cnt_reg <= '0;
          wr_cnt_reg <= '0;
          state_reg <= E_RUN;
        end
        E_RUN: begin
          if (|rd_pick) begin
            rd_cnt_reg <= rd_cnt_reg + 3'h1;
            rd_off_reg <= rd_off_reg + {13'h0, elem_bytes};
            if (!td_reg.endless) begin
              left_reg <= (left_reg > {14'h0, elem_bytes}) ? left_reg - {14'h0, elem_bytes} : '0;
            end
          end
          if (|wr_pick) begin
            wr_cnt_reg <= wr_cnt_reg + 3'h1;
            wr_off_reg <= wr_off_reg + {13'h0, elem_bytes};
          end
          if (burst_end) begin
            state_reg <= E_STEP; // [R16]
          end
        end
        E_STEP: begin
          state_reg <= E_IDLE;
        end
        default: begin
          state_reg <= E_IDLE;
        end
      endcase
    end
  end

  // dma bus outputs captured at issue
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr_reg <= '0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      size_reg <= '0;
    end else begin
      if (|rd_pick) begin
        rd_addr_reg <= rd_addr;
        size_reg <= td_reg.size_m1;
      end
      if (|wr_pick) begin
        wr_addr_reg <= wr_addr;
        wr_data_reg <= f_out_data;
        size_reg <= td_reg.size_m1;
      end
    end
  end

  // channel state: triggers, progress, chaining, cancel
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_reg <= '0;
      fresh_reg <= '0;
      irq_td_reg <= '0;
      irq_end_reg <= '0;
      for (int c = 0; c < NCH; c++) begin
        ch_td_reg[c] <= '0;
        ch_left_reg[c] <= '0;
        ch_off_reg[c] <= '0;
      end
    end else begin
      irq_td_reg <= '0;
      irq_end_reg <= '0;
      if (state_reg == E_STEP) begin
        ch_left_reg[eng_ch_reg] <= left_reg;
        ch_off_reg[eng_ch_reg] <= wr_off_reg;
        fresh_reg[eng_ch_reg] <= 1'b0;
        if (step_done && active_reg[eng_ch_reg]) begin
          irq_td_reg[eng_ch_reg] <= td_reg.irq_td; // [R11]
          if (td_reg.chain) begin
            ch_td_reg[eng_ch_reg] <= td_reg.next; // [R8]
            fresh_reg[eng_ch_reg] <= 1'b1;
          end else begin
            active_reg[eng_ch_reg] <= 1'b0;
            irq_end_reg[eng_ch_reg] <= td_reg.irq_end; // [R11]
          end
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (ch_cancel[c]) begin
          active_reg[c] <= 1'b0; // [R12]
        end
        // start of an idle channel wins over its cancel; a start while it is still active, even as it completes, is lost
        if (!active_reg[c] && (trig_rise[c] || ch_cpu_trig[c]
            || (step_end && td_reg.trig_en && td_reg.trig_ch == 5'(c)))) begin
          active_reg[c] <= 1'b1; // [R10]
          fresh_reg[c] <= 1'b1;
          ch_td_reg[c] <= ch_cfg[c].first_td;
        end
      end
    end
  end
endmodule : hub_dma_priority_arbiter

// >>> hub_pkg.sv
// shared constants and carrier types of the peripheral hub arbiter
package hub_pkg;
  localparam int NUM_SPOKES = 8;
  localparam int NUM_CH = 24;
  localparam int NUM_TD = 128;
  localparam int TD_IDX_W = 7;
  localparam int BURST_LEN = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int DATA_W = 32;
  localparam int SPOKE_LSB = 16;
  localparam int NUM_LVL = 8;
  localparam int WIN_W = 7;
  localparam int FAIR_FIRST_LVL = 2;
  localparam int FAIR_LAST_LVL = 7;
  localparam int LEFT_W = 17;
  // spoke map of the main targets
  localparam logic [2:0] SPOKE_SRAM = 3'h0;
  localparam logic [2:0] SPOKE_ANALOG = 3'h3;
  localparam logic [2:0] SPOKE_PDB_GRP1 = 3'h6;
  localparam logic [2:0] SPOKE_PDB_GRP2 = 3'h7;

  // one transfer_descriptor
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] len_m1;
    logic endless;
    logic [1:0] size_m1;
    logic src_inc;
    logic dst_inc;
    logic chain;
    logic [TD_IDX_W-1:0] next;
    logic irq_td;
    logic irq_end;
    logic trig_en;
    logic [4:0] trig_ch;
  } td_t;

  // per channel setup
  typedef struct packed {
    logic [2:0] prio;
    logic no_rr;
    logic [TD_IDX_W-1:0] first_td;
  } ch_cfg_t;

  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_LOAD = 4'h2,
    E_RUN = 4'h4,
    E_STEP = 4'h8
  } eng_state_t;
endpackage : hub_pkg

// >>> hub_arb_chk_sva.sv
// port assertions of the peripheral hub arbiter
`timescale 1ns/10ps
module hub_arb_chk import hub_pkg::*; #(
  parameter int NCH = NUM_CH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_req,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_ack,
  input wire logic [NUM_SPOKES-1:0] cpu_gnt,
  input wire logic [NUM_SPOKES-1:0] dma_rd_gnt,
  input wire logic [NUM_SPOKES-1:0] dma_wr_gnt,
  input wire logic [NUM_SPOKES-1:0] spoke_done,
  input wire logic [NCH-1:0] ch_busy,
  input wire logic [NCH-1:0] irq_td,
  input wire logic [NCH-1:0] irq_end
);
  logic [6:0] quiet_reg;
  // cycles since a channel was last active; a cancelled burst still finishes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet_reg <= 7'h7F;
    end else if (ch_busy != '0) begin
      quiet_reg <= 7'h00;
    end else if (quiet_reg != 7'h7F) begin
      quiet_reg <= quiet_reg + 7'h01;
    end
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // spoke ownership and grant lifetime
  one_owner_a: assert property (((cpu_gnt & (dma_rd_gnt | dma_wr_gnt)) | (dma_rd_gnt & dma_wr_gnt)) == 8'h00)
    else $error("spoke with two owners");
  cpu_hold_a: assert property (1'b1 |=> (($past(cpu_gnt & ~spoke_done) & ~cpu_gnt) == 8'h00))
    else $error("cpu grant lost before done");
  cpu_release_a: assert property (1'b1 |=> ((cpu_gnt & $past(cpu_gnt & spoke_done)) == 8'h00))
    else $error("cpu grant kept after done");
  // cpu acknowledge timing, granted spoke and wait for grant
  ack_cause_a: assert property (cpu_ack |-> $past(|(cpu_gnt & spoke_done)))
    else $error("ack without finished access");
  ack_due_a: assert property (|(cpu_gnt & spoke_done) |=> cpu_ack ##1 !cpu_ack)
    else $error("ack missing or too long");
  cpu_spoke_a: assert property ((cpu_gnt & ~$past(cpu_gnt)) != 8'h00 |->
    $past(cpu_req) && cpu_gnt == (8'h01 << $past(cpu_addr[18:16]))) else $error("cpu granted wrong spoke");
  cpu_wait_a: assert property ($rose(cpu_req) |-> ##[1:40] (cpu_gnt != 8'h00))
    else $error("cpu kept waiting");
  // dma grants and interrupt pulses
  rd_single_a: assert property ($onehot0(dma_rd_gnt) && $onehot0(dma_wr_gnt))
    else $error("more than one dma read or write");
  dma_cause_a: assert property ((dma_rd_gnt & ~$past(dma_rd_gnt)) != 8'h00 |-> quiet_reg < 7'h40)
    else $error("dma read with no active channel");
  irq_pulse_a: assert property (((irq_td & $past(irq_td)) | (irq_end & $past(irq_end))) == '0)
    else $error("interrupt pulse too long");
endmodule : hub_arb_chk

bind hub_dma_priority_arbiter hub_arb_chk #(.NCH(NCH)) chk (
  .clk(clk), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_ack(cpu_ack),
  .cpu_gnt(cpu_gnt), .dma_rd_gnt(dma_rd_gnt), .dma_wr_gnt(dma_wr_gnt), .spoke_done(spoke_done),
  .ch_busy(ch_busy), .irq_td(irq_td), .irq_end(irq_end)
);

// >>> hub_spoke_model.sv
// spoke peripherals answering grants with done pulses and read data
`timescale 1ns/10ps
module hub_spoke_model #(
  parameter logic [31:0] MIX = 32'hC3C3_C3C3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] slow_mask,
  input wire logic [7:0] cpu_gnt,
  input wire logic [7:0] dma_rd_gnt,
  input wire logic [7:0] dma_wr_gnt,
  input wire logic [31:0] dma_rd_addr,
  output logic [7:0] spoke_done,
  output logic [31:0] dma_rdata
);
  logic [2:0] wait_reg [8];
  // per spoke wait, then one done pulse; read data valid only with it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      spoke_done <= 8'h00;
      dma_rdata <= 32'h0;
      for (int s = 0; s < 8; s++) begin
        wait_reg[s] <= 3'h0;
      end
    end else begin
      dma_rdata <= ~dma_rdata; // no stale data between reads
      for (int s = 0; s < 8; s++) begin
        spoke_done[s] <= 1'b0;
        if (!(cpu_gnt[s] | dma_rd_gnt[s] | dma_wr_gnt[s]) || spoke_done[s]) begin
          wait_reg[s] <= 3'h0;
        end else if (wait_reg[s] == (slow_mask[s] ? 3'h4 : 3'h0)) begin
          spoke_done[s] <= 1'b1;
          if (dma_rd_gnt[s]) dma_rdata <= dma_rd_addr ^ MIX;
        end else begin
          wait_reg[s] <= wait_reg[s] + 3'h1;
        end
      end
    end
  end
endmodule : hub_spoke_model

// >>> hub_dma_priority_arbiter_test.sv
// self-checking bench of the peripheral hub arbiter
`timescale 1ns/10ps
module hub_dma_priority_arbiter_test import hub_pkg::*;;
  localparam logic [31:0] MIX = 32'hC3C3_C3C3;
  logic clk, sys_rst, cpu_req, cpu_ack, td_wr, fair_en, both_seen, rw_seen;
  logic [31:0] cpu_addr, dma_rd_addr, dma_wr_addr, dma_wr_data, dma_rdata, ra_prev, wa_prev;
  logic [7:0] cpu_gnt, dma_rd_gnt, dma_wr_gnt, spoke_done, slow_mask, rd_prev, wr_prev;
  logic [1:0] dma_size_m1;
  logic [6:0] td_wr_idx;
  td_t td_wr_data, td;
  ch_cfg_t [23:0] ch_cfg;
  logic [23:0] ch_trig_sig, ch_cpu_trig, ch_stall, ch_cancel, ch_busy, irq_td, irq_end;
  logic [31:0] rd_log[$], wr_log[$], wd_log[$];
  logic [1:0] sz_log[$];
  int num_errors, total_checks, cyc;

  hub_dma_priority_arbiter dut (.clk(clk), .sys_rst(sys_rst), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .cpu_ack(cpu_ack), .cpu_gnt(cpu_gnt), .dma_rd_gnt(dma_rd_gnt), .dma_wr_gnt(dma_wr_gnt),
    .dma_rd_addr(dma_rd_addr), .dma_wr_addr(dma_wr_addr), .dma_wr_data(dma_wr_data),
    .dma_size_m1(dma_size_m1), .spoke_done(spoke_done), .dma_rdata(dma_rdata), .td_wr(td_wr),
    .td_wr_idx(td_wr_idx), .td_wr_data(td_wr_data), .ch_cfg(ch_cfg), .fair_en(fair_en),
    .ch_trig_sig(ch_trig_sig), .ch_cpu_trig(ch_cpu_trig), .ch_stall(ch_stall), .ch_cancel(ch_cancel),
    .ch_busy(ch_busy), .irq_td(irq_td), .irq_end(irq_end));
  hub_spoke_model #(.MIX(MIX)) peer (.clk(clk), .sys_rst(sys_rst), .slow_mask(slow_mask),
    .cpu_gnt(cpu_gnt), .dma_rd_gnt(dma_rd_gnt), .dma_wr_gnt(dma_wr_gnt), .dma_rd_addr(dma_rd_addr),
    .spoke_done(spoke_done), .dma_rdata(dma_rdata));

  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // overlap flags, grant log, cycle ceiling
  always @(negedge clk) begin
    if (cpu_gnt != 8'h00 && (dma_rd_gnt | dma_wr_gnt) != 8'h00) both_seen = 1'b1;
    if (dma_rd_gnt != 8'h00 && dma_wr_gnt != 8'h00) rw_seen = 1'b1;
    if (dma_rd_gnt != 8'h00 && (dma_rd_gnt != rd_prev || dma_rd_addr != ra_prev)) begin
      rd_log.push_back(dma_rd_addr);
      sz_log.push_back(dma_size_m1);
    end
    if (dma_wr_gnt != 8'h00 && (dma_wr_gnt != wr_prev || dma_wr_addr != wa_prev)) begin
      wr_log.push_back(dma_wr_addr);
      wd_log.push_back(dma_wr_data);
    end
    {rd_prev, wr_prev, ra_prev, wa_prev} = {dma_rd_gnt, dma_wr_gnt, dma_rd_addr, dma_wr_addr};
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("[ERR] %0t run too long", $time);
      results();
    end
  end

  function automatic td_t mk(input logic [31:0] s, input logic [31:0] d, input logic [15:0] n);
    td_t t;
    t = '0;
    {t.src, t.dst, t.len_m1} = {s, d, n};
    {t.src_inc, t.dst_inc, t.irq_td, t.irq_end} = 4'hF;
    return t;
  endfunction : mk

  task automatic load_td(input int c, input logic [6:0] idx, input td_t d, input logic [2:0] p, input logic hol);
    @(posedge clk);
    td_wr <= 1'b1;
    td_wr_idx <= idx;
    td_wr_data <= d;
    ch_cfg[c] <= '{p, hol, idx};
    @(posedge clk);
    td_wr <= 1'b0;
  endtask : load_td

  task automatic fire(input logic [23:0] m, input logic pin);
    rd_log.delete();
    wr_log.delete();
    wd_log.delete();
    sz_log.delete();
    @(posedge clk);
    if (pin) ch_trig_sig <= m;
    else ch_cpu_trig <= m;
    repeat (pin ? 3 : 1) @(posedge clk); // pins need two agreeing sync stages
    ch_trig_sig <= 24'h0;
    ch_cpu_trig <= 24'h0;
  endtask : fire

  // wait for a channel's end, then check its pulses
  task automatic go(input int c);
    logic e;
    logic t;
    {e, t} = 2'h0;
    for (int i = 0; i < 800 && !e; i++) begin
      @(negedge clk);
      t = t | irq_td[c];
      e = irq_end[c] === 1'b1;
    end
    cmp(32'(e), 32'h1, "end pulse");
    cmp(32'(t), 32'h1, "descriptor pulse");
    repeat (3) @(negedge clk);
    cmp(32'(ch_busy[c]), 32'h0, "busy after end");
  endtask : go

  task automatic cpu_access(input logic [31:0] a);
    logic k;
    k = 1'b0;
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_addr <= a;
    for (int i = 0; i < 60 && !k; i++) begin
      @(negedge clk);
      k = cpu_ack === 1'b1;
      if (cpu_gnt != 8'h00) cmp(32'(cpu_gnt), 32'(8'h01 << a[18:16]), "cpu spoke");
    end
    cmp(32'(k), 32'h1, "cpu ack");
    @(posedge clk);
    cpu_req <= 1'b0;
  endtask : cpu_access

  // reset, then the scenarios in turn
  initial begin
    sys_rst = 1'b1;
    {cpu_req, td_wr, fair_en, both_seen, rw_seen, cpu_addr, td_wr_idx, td_wr_data, slow_mask} = '0;
    {ch_cfg, ch_trig_sig, ch_cpu_trig, ch_stall, ch_cancel, num_errors, total_checks, cyc} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    cmp(32'(cpu_gnt | dma_rd_gnt | dma_wr_gnt), 32'h0, "grants after reset");
    for (int s = 0; s < 8; s++) cpu_access({13'h0, 3'(s), 16'h0});
    fair_en <= 1'b1;
    for (int z = 0; z < 4; z++) begin
      td = mk(32'h0003_0010, 32'h0000_0020, 16'(z));
      td.size_m1 = 2'(z);
      load_td(0, 7'h00, td, 3'h0, 1'b0);
      fire(24'h1, 1'b0);
      go(0);
      cmp(32'(sz_log[0]), 32'(z), "element size");
      cmp(rd_log[0], 32'h0003_0010, "source");
      cmp(wr_log[0], 32'h0000_0020, "sink");
      cmp(wd_log[0], 32'h0003_0010 ^ MIX, "moved word");
    end
    // cpu beside a long transfer with a slow sink
    slow_mask <= 8'h01;
    load_td(0, 7'h00, mk(32'h0003_0000, 32'h0000_0040, 16'h000F), 3'h0, 1'b0);
    fire(24'h1, 1'b0);
    fork
      go(0);
      begin
        repeat (8) @(posedge clk);
        cpu_access(32'h0005_0000);
        cpu_access(32'h0000_0000);
      end
    join
    cmp(32'(both_seen), 32'h1, "cpu beside dma");
    cmp(32'(rw_seen), 32'h1, "read beside write");
    // level 1 takes over level 5 at its burst end
    load_td(1, 7'h01, mk(32'h0001_0000, 32'h0000_0100, 16'h0007), 3'h5, 1'b0);
    {slow_mask, fair_en} <= '0;
    load_td(2, 7'h02, mk(32'h0002_0000, 32'h0000_0200, 16'h0007), 3'h1, 1'b0);
    fire(24'h2, 1'b0);
    for (int i = 0; i < 50 && rd_log.size() == 0; i++) @(posedge clk);
    @(posedge clk);
    ch_cpu_trig <= 24'h4;
    @(posedge clk);
    ch_cpu_trig <= 24'h0;
    go(1);
    for (int i = 0; i < 16; i++) cmp(32'(rd_log[i][18:16]), (i < 4 || i > 11) ? 1 : 2, "takeover");
    // equal level channels, rotating, head of line, then fairness slots
    for (int h = 0; h < 3; h++) begin
      load_td(3, 7'h03, mk(32'h0004_0000, 32'h0000_0300, 16'h0007), (h == 2) ? 3'h2 : 3'h4, 1'b0);
      fair_en <= (h == 2);
      load_td(4, 7'h04, mk(32'h0005_0000, 32'h0000_0400, 16'h0007), (h == 2) ? 3'h3 : 3'h4, 1'(h));
      fire(24'h18, 1'b0);
      go((h == 1) ? 3 : 4);
      for (int i = 0; i < 16; i++) cmp(32'(rd_log[i][18:16]), (h == 1) ? (i < 8 ? 5 : 4) : (i[2] ? 5 : 4), "turns");
    end
    // stalled, then endless, then cancelled
    td = mk(32'h0006_0000, 32'h0007_0000, 16'h0000);
    td.endless = 1'b1;
    load_td(7, 7'h07, td, 3'h0, 1'b0);
    ch_stall <= 24'h80;
    fire(24'h80, 1'b0);
    repeat (30) @(negedge clk);
    cmp(32'(rd_log.size()), 32'h0, "stalled reads");
    cmp(32'(ch_busy[7]), 32'h1, "stalled busy");
    @(posedge clk);
    ch_stall <= 24'h0;
    repeat (100) @(negedge clk);
    cmp(32'(ch_busy[7] === 1'b1 && rd_log.size() > 8), 32'h1, "endless run");
    @(posedge clk);
    ch_cancel <= 24'h80;
    repeat (40) @(posedge clk);
    ch_cancel <= 24'h0;
    @(negedge clk);
    cmp(32'(ch_busy[7]), 32'h0, "cancelled");
    // pin start, then start by another channel's completion
    td = mk(32'h0002_0000, 32'h0000_0500, 16'h0003);
    {td.trig_en, td.trig_ch} = {1'b1, 5'h06};
    load_td(5, 7'h05, td, 3'h2, 1'b0);
    load_td(6, 7'h06, mk(32'h0001_0000, 32'h0000_0600, 16'h0003), 3'h2, 1'b0);
    fire(24'h20, 1'b1);
    go(5);
    go(6);
    results();
  end
endmodule : hub_dma_priority_arbiter_test
